/* src/rtid_core.v */
// RTC interrupt, divider control and alarm compare core
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "rtid_map.vh"
module rtid_core (
  input wire sys_clk,
  input wire rst,
  input wire osc_in,
  input wire [5:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  input wire updateDone,
  output reg [7:0] regRdata,
  output reg irq_n,
  output reg secTick,
  output reg leapYear
);
  // Time base pin synchroniser
  reg osc1_q;
  reg osc2_q;
  reg osc3_q;
  // Software registers
  reg [7:0] ctlA_q;
  reg [7:0] ctlB_q;
  reg [7:0] secAl_q;
  reg [7:0] minAl_q;
  reg [7:0] hrAl_q;
  reg [7:0] sec_q;
  reg [7:0] min_q;
  reg [7:0] hr_q;
  reg [7:0] year_q;
  // Divider and flags
  wire divSec;
  wire divPer;
  wire [2:0] flags;
  wire statRead;
  wire tbEdge;
  reg alarmHit;
  reg [2:0] evSet;
  reg [2:0] enables;
  reg [7:0] rdMux_d;
  reg lineActive;
  wire [2:0] flagsAfter;

  // Sample pin through two flops, then edge detect on later stages
  always @(posedge sys_clk) begin
    if (rst) begin
      osc1_q <= 1'b0;
      osc2_q <= 1'b0;
      osc3_q <= 1'b0;
    end else begin
      osc1_q <= osc_in;
      osc2_q <= osc1_q;
      osc3_q <= osc2_q;
    end
  end
  assign tbEdge = osc2_q && !osc3_q;
  assign statRead = regRd && (regAddr == `RTID_REG_STAT);

  rtid_divider #(
    .STAGES(`RTID_STAGES)
  ) uDiv (
    .sys_clk(sys_clk),
    .rst(rst),
    .tbEdge(tbEdge),
    .divSel(ctlA_q[`RTID_A_DV_LSB+2:`RTID_A_DV_LSB]),
    .rateSel(ctlA_q[`RTID_A_RS_LSB+3:`RTID_A_RS_LSB]),
    .secTick(divSec),
    .perTick(divPer)
  );

  // Alarm compare with don't-care bytes
  always @* begin
    alarmHit = ((secAl_q[7:6] == `RTID_DONTCARE) || (secAl_q == sec_q)) &&
      ((minAl_q[7:6] == `RTID_DONTCARE) || (minAl_q == min_q)) &&
      ((hrAl_q[7:6] == `RTID_DONTCARE) || (hrAl_q == hr_q));
    // Event order: update-ended, alarm, periodic
    evSet = {divPer, updateDone && alarmHit, updateDone};
    enables = {ctlB_q[`RTID_B_PIE], ctlB_q[`RTID_B_AIE], ctlB_q[`RTID_B_UIE]};
  end

  rtid_flags uFlags (
    .sys_clk(sys_clk),
    .rst(rst),
    .evSet(evSet),
    .statRead(statRead),
    .flag_q(flags),
    .snap_q()
  );
  // Flags as they stand after this cycle, so the line follows at once
  assign flagsAfter = statRead ? evSet : (flags | evSet);

  // Next-cycle line level; uses next enable value so enabling acts at once
  always @* begin
    lineActive = |(flagsAfter & enables);
    if (regWr && regAddr == `RTID_REG_CTLB) begin
      lineActive = |(flagsAfter & {regWdata[`RTID_B_PIE], regWdata[`RTID_B_AIE],
        regWdata[`RTID_B_UIE]});
    end
  end

  // Software writes; time bytes kept so alarm compare sees them
  always @(posedge sys_clk) begin
    if (rst) begin
      ctlA_q <= `RTID_CTLA_RST;
      ctlB_q <= `RTID_CTLB_RST;
      secAl_q <= 8'h00;
      minAl_q <= 8'h00;
      hrAl_q <= 8'h00;
      sec_q <= 8'h00;
      min_q <= 8'h00;
      hr_q <= 8'h00;
      year_q <= 8'h00;
    end else if (regWr) begin
      case (regAddr)
        `RTID_REG_SEC: sec_q <= regWdata;
        `RTID_REG_SECAL: secAl_q <= regWdata;
        `RTID_REG_MIN: min_q <= regWdata;
        `RTID_REG_MINAL: minAl_q <= regWdata;
        `RTID_REG_HR: hr_q <= regWdata;
        `RTID_REG_HRAL: hrAl_q <= regWdata;
        `RTID_REG_YEAR: year_q <= regWdata;
        `RTID_REG_CTLA: ctlA_q <= {1'b0, regWdata[6:0]}; // Bit 7 read only
        `RTID_REG_CTLB: ctlB_q <= regWdata;
        default: ctlB_q <= ctlB_q;
      endcase
    end
  end

  // Read data mux; status uses flag_q as it stands at the read edge
  always @* begin
    case (regAddr)
      `RTID_REG_SEC: rdMux_d = sec_q;
      `RTID_REG_SECAL: rdMux_d = secAl_q;
      `RTID_REG_MIN: rdMux_d = min_q;
      `RTID_REG_MINAL: rdMux_d = minAl_q;
      `RTID_REG_HR: rdMux_d = hr_q;
      `RTID_REG_HRAL: rdMux_d = hrAl_q;
      `RTID_REG_YEAR: rdMux_d = year_q;
      `RTID_REG_CTLA: rdMux_d = ctlA_q;
      `RTID_REG_CTLB: rdMux_d = ctlB_q;
      default: rdMux_d = 8'h00; // Unmapped reads zero
    endcase
  end

  // Outputs all registered
  always @(posedge sys_clk) begin
    if (rst) begin
      regRdata <= 8'h00;
      irq_n <= 1'b1;
      secTick <= 1'b0;
      leapYear <= 1'b1;
    end else begin
      if (statRead) begin
        // Summary bit equals line state at read time
        regRdata <= {~irq_n, flags[2], flags[1], flags[0], 4'h0};
      end else if (regRd) begin
        regRdata <= rdMux_d;
      end else begin
        regRdata <= 8'h00;
      end
      irq_n <= ~lineActive;
      // SET bit stops the tick to update logic but not the divider
      secTick <= divSec && !ctlB_q[`RTID_B_SET];
      leapYear <= (year_q[1:0] == 2'b00);
    end
  end
endmodule // rtid_core
`default_nettype wire

/* src/rtid_map.vh */
// Register offsets, field positions, reset values and timing counts of the RTC interrupt block
// Summary of operation
// - Year multiple of four, zero included, leaps
// - Alarm, periodic and update-ended interrupt sources
// - Alarm per second..day; periodic 500ms..30.517us
// - Per-source enable bit gates interrupt line
// - Enabling an already-set flag asserts at once
// - Events set flags regardless of enables
// - Status read clears set flags and summary
// - Status double-latched; events during read held
// - Line low while any flag and enable set
// - Summary flag bit 7 mirrors line low
// - Twenty-two divider stages give 1 Hz tick
// - Codes 000/001/010 bypass 0/2/7 stages
// - Codes 110 and 111 hold divider reset
// - First update half second after leaving reset
// - Update-ended flag sets on each completed update
// - Alarm byte C0..FF matches any value
// - Periodic own enable; rate from rate-select bits
`ifndef RTID_MAP_VH
`define RTID_MAP_VH
// Register indices
`define RTID_REG_SEC 6'h00
`define RTID_REG_SECAL 6'h01
`define RTID_REG_MIN 6'h02
`define RTID_REG_MINAL 6'h03
`define RTID_REG_HR 6'h04
`define RTID_REG_HRAL 6'h05
`define RTID_REG_YEAR 6'h09
`define RTID_REG_CTLA 6'h0A
`define RTID_REG_CTLB 6'h0B
`define RTID_REG_STAT 6'h0C
// Control A fields
`define RTID_A_RS_LSB 0
`define RTID_A_DV_LSB 4
// Control B fields
`define RTID_B_UIE 4
`define RTID_B_AIE 5
`define RTID_B_PIE 6
`define RTID_B_SET 7
// Status fields
`define RTID_S_UF 4
`define RTID_S_AF 5
`define RTID_S_PF 6
`define RTID_S_IRQF 7
// Reset values
`define RTID_CTLA_RST 8'h70
`define RTID_CTLB_RST 8'h00
// Divider codes
`define RTID_DV_N0 3'h0
`define RTID_DV_N2 3'h1
`define RTID_DV_N7 3'h2
// Chain length and half-second tap
`define RTID_STAGES 22
`define RTID_HALF_TAP 21
// Don't-care alarm marker
`define RTID_DONTCARE 2'h3
`endif

/* src/rtid_divider.v */
// 22-stage time-base divider with bypass and hold
`timescale 1ns/100ps
`default_nettype none
`include "rtid_map.vh"
module rtid_divider #(
  parameter STAGES = `RTID_STAGES
) (
  input wire sys_clk,
  input wire rst,
  input wire tbEdge,
  input wire [2:0] divSel,
  input wire [3:0] rateSel,
  output reg secTick,
  output reg perTick
);
  // Chain counter; bypass by adding each edge in at a higher stage
  reg [STAGES-1:0] cnt_q;
  reg [STAGES-1:0] cntNext;
  reg held;
  reg [STAGES-1:0] stepVal;
  reg [4:0] tap;
  // Hold and bypass decode
  always @* begin
    held = (divSel[2:1] == 2'b11);
    case (divSel)
      `RTID_DV_N0: stepVal = {{(STAGES-1){1'b0}}, 1'b1};
      `RTID_DV_N2: stepVal = {{(STAGES-3){1'b0}}, 3'b100};
      `RTID_DV_N7: stepVal = {{(STAGES-8){1'b0}}, 8'h80};
      default: stepVal = {STAGES{1'b0}};
    endcase
    cntNext = cnt_q + stepVal;
    // Periodic tap: code 1 -> bit 6 (128 counts) ... code 15 -> bit 20 (half second)
    tap = 5'h05 + {1'b0, rateSel};
  end
  // Counter; release from hold starts at half second so first tick is 0.5 s later
  always @(posedge sys_clk) begin
    if (rst || held) begin
      // Top stage set: exactly half the chain remains before the carry
      cnt_q <= {1'b1, {(STAGES-1){1'b0}}};
      secTick <= 1'b0;
      perTick <= 1'b0;
    end else begin
      if (tbEdge) begin
        cnt_q <= cntNext;
      end
      // Carry out of top stage is the 1 Hz tick
      secTick <= tbEdge && cnt_q[STAGES-1] && !cntNext[STAGES-1];
      perTick <= tbEdge && (rateSel != 4'h0) && cnt_q[tap] && !cntNext[tap];
    end
  end
endmodule // rtid_divider
`default_nettype wire

/* src/rtid_flags.v */
// Double-latched read-clearing status flags
`timescale 1ns/100ps
`default_nettype none
`include "rtid_map.vh"
module rtid_flags (
  input wire sys_clk,
  input wire rst,
  input wire [2:0] evSet,
  input wire statRead,
  output reg [2:0] flag_q,
  output reg [2:0] snap_q
);
  // Snapshot taken at read; read clears only what was set then
  always @(posedge sys_clk) begin
    if (rst) begin
      flag_q <= 3'h0;
      snap_q <= 3'h0;
    end else begin
      if (statRead) begin
        snap_q <= flag_q;
        flag_q <= evSet;
      end else begin
        flag_q <= flag_q | evSet;
      end
    end
  end
endmodule // rtid_flags
`default_nettype wire

/* testbench/rtid_time_base.sv */
// Time base and update-logic model facing the core
`timescale 1ns/100ps
`default_nettype none
module rtid_time_base (
  input wire logic sys_clk,
  input wire logic oscRun,
  input wire logic updReq,
  output logic osc_in,
  output logic updateDone
);
  logic [1:0] ph_q = 2'h0; // Four-cycle time base phase
  logic upd_q = 1'b0; // Update-ended pulse
  // Time base stands low while stopped
  always @(posedge sys_clk) begin
    ph_q <= oscRun ? ph_q + 2'h1 : 2'h0;
    upd_q <= updReq;
  end
  assign osc_in = ph_q[1];
  assign updateDone = upd_q;
endmodule // rtid_time_base
`default_nettype wire

/* testbench/rtid_core_asserts.sv */
// Port checker for the RTC interrupt core
`timescale 1ns/100ps
`default_nettype none
module rtid_core_asserts (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic updateDone,
  input wire logic [7:0] regRdata,
  input wire logic irq_n,
  input wire logic secTick,
  input wire logic leapYear
);
  wire logic stRd = regRd && regAddr == 6'h0C; // Status read
  wire logic bWr = regWr && regAddr == 6'h0B; // Enable write
  wire logic yWr = regWr && regAddr == 6'h09; // Year write
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_summary_bit: assert property (stRd |=> regRdata[7] == !$past(irq_n))
    else $error("summary bit wrong");
  chk_read_clears: assert property (stRd && !updateDone ##1 stRd && !updateDone
    |=> regRdata[5:4] == 2'h0)
    else $error("flags not cleared");
  chk_update_flag: assert property (updateDone ##1 stRd |=> regRdata[4])
    else $error("update flag lost");
  chk_late_enable: assert property (updateDone ##1 (bWr && regWdata[4]) |=> !irq_n)
    else $error("late enable ignored");
  chk_all_masked: assert property (bWr && regWdata[6:4] == 3'h0 |=> irq_n)
    else $error("masked line low");
  chk_leap_set: assert property (yWr && regWdata[1:0] == 2'h0 |-> ##2 leapYear)
    else $error("leap year missed");
  chk_leap_clear: assert property (yWr && regWdata[1:0] != 2'h0 |-> ##2 !leapYear)
    else $error("false leap year");
  chk_tick_pulse: assert property (secTick |=> !secTick)
    else $error("tick too long");
endmodule // rtid_core_asserts
bind rtid_core rtid_core_asserts uChk (.sys_clk, .rst, .regAddr, .regWdata, .regWr,
  .regRd, .updateDone, .regRdata, .irq_n, .secTick, .leapYear);
`default_nettype wire

/* testbench/tb_top.sv */
// Register-level bench for the RTC interrupt core
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] regAddr = 6'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic oscRun = 1'b0; // Time base gate
  logic updReq = 1'b0; // Update-ended request
  wire logic osc_in;
  wire logic updateDone;
  wire logic [7:0] regRdata;
  wire logic irq_n;
  wire logic secTick;
  wire logic leapYear;
  int fails = 0;
  int checked = 0;
  int i;
  int j;
  always #5 sys_clk = ~sys_clk;
  rtid_time_base far (.sys_clk, .oscRun, .updReq, .osc_in, .updateDone);
  rtid_core dut (.sys_clk, .rst, .osc_in, .regAddr, .regWdata, .regWr, .regRd,
    .updateDone, .regRdata, .irq_n, .secTick, .leapYear);
  task automatic summarize;
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Idle the bus, optionally request an update end
  task automatic step(input int n, input logic u);
    regWr <= 1'b0;
    regRd <= 1'b0;
    updReq <= u;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    regRd <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    regAddr <= a;
    regRd <= 1'b1;
    regWr <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(regRdata & m, e);
  endtask
  // Two ticks; c is the expected spacing in cycles
  task automatic per(input logic [7:0] a, input int c);
    wr(6'h0A, a);
    rd(6'h0C, 8'h00, 8'h00);
    for (i = 0; i < 4000 && irq_n !== 1'b0; i++)
      step(1, 1'b0);
    rd(6'h0C, 8'hC0);
    for (i = 0; i < 4000 && irq_n !== 1'b0; i++)
      step(1, 1'b0);
    chk({7'h00, i > c - 20 && i < c + 20}, 8'h01);
    if (fails != 0)
      summarize();
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    step(1, 1'b0);
    rd(6'h0A, 8'h70);
    wr(6'h0A, 8'hF0);
    rd(6'h0A, 8'h70);
    wr(6'h3F, 8'hFF);
    rd(6'h3F, 8'h00);
    for (i = 0; i < 8; i++) begin
      wr(6'h09, i[7:0]);
      step(1, 1'b0);
      chk({7'h00, leapYear}, {7'h00, i[1:0] == 2'h0});
    end
    wr(6'h01, 8'hC0);
    wr(6'h03, 8'hFF);
    wr(6'h05, 8'hE7);
    step(1, 1'b1);
    step(1, 1'b0);
    chk({7'h00, irq_n}, 8'h01);
    rd(6'h0C, 8'h30);
    rd(6'h0C, 8'h00);
    wr(6'h01, 8'h15);
    step(1, 1'b1);
    step(1, 1'b0);
    rd(6'h0C, 8'h10);
    wr(6'h00, 8'h15);
    step(1, 1'b1);
    step(1, 1'b0);
    wr(6'h0B, 8'h10);
    chk({7'h00, irq_n}, 8'h00);
    rd(6'h0C, 8'hB0);
    chk({7'h00, irq_n}, 8'h01);
    // Event lands in the read cycle
    step(1, 1'b1);
    rd(6'h0C, 8'h00);
    step(1, 1'b0);
    rd(6'h0C, 8'hB0);
    step(1, 1'b1);
    step(1, 1'b0);
    wr(6'h0B, 8'h00);
    chk({7'h00, irq_n}, 8'h01);
    rd(6'h0C, 8'h30);
    wr(6'h0B, 8'h40);
    oscRun <= 1'b1;
    per(8'h01, 512);
    per(8'h11, 128);
    for (j = 0; j < 2; j++) begin
      wr(6'h0A, j ? 8'h71 : 8'h61);
      rd(6'h0C, 8'h00, 8'h00);
      step(600, 1'b0);
      chk({7'h00, irq_n}, 8'h01);
      rd(6'h0C, 8'h00);
    end
    wr(6'h0A, 8'h20);
    for (i = 0; i < 70000 && secTick !== 1'b1; i++)
      step(1, 1'b0);
    chk({7'h00, i > 65500 && i < 65600}, 8'h01);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
